// ---- rtl/lhi_core.sv ----
// Notes on behaviour
// (RULE_01) Selector 0..7 gives interval 2^13,17,18,20,22,24,26,30; resets to code 3.
// (RULE_02) Incremental: homes every interval multiple from first mark after start.
// (RULE_03) Operator puts a reference mark ahead in the homing direction.
// (RULE_04) Operator enables multi-mark input when scale has two or more marks.
// (RULE_05) Absolute: homes every interval multiple counted from position zero.
// (RULE_06) Stored pole data can be read out and written in.
// (RULE_07) Operator cycles power before written pole data is relied upon.
// (RULE_08) Home hit when offset low bits up to the exponent are all zero.
`timescale 1ns/10ps
module lhi_core #(
    parameter int POS_W = lhi_pkg::POS_W
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     arst_n_i,
    input  wire logic [POS_W-1:0]         position_i,
    input  wire logic                     ref_mark_i,
    input  wire logic                     homing_start_i,
    input  wire logic                     encoder_absolute_i,
    input  wire logic [lhi_pkg::SEL_W-1:0] homing_interval_select_i,
    input  wire logic                     multi_reference_mark_enable_i,
    input  wire logic                     pole_wr_en_i,
    input  wire logic                     pole_rd_en_i,
    input  wire logic [lhi_pkg::POLE_AW-1:0] pole_addr_i,
    input  wire logic [lhi_pkg::POLE_W-1:0]  pole_wdata_i,
    output logic      [lhi_pkg::POLE_W-1:0]  pole_rdata_o,
    output logic                          pole_rvalid_o,
    output logic                          pole_written_o,
    output logic                          seeking_o,
    output logic                          armed_o,
    output logic                          home_hit_o,
    output logic                          extra_mark_o,
    output logic      [POS_W-1:0]         reference_pos_o,
    output logic      [lhi_pkg::EXP_W-1:0] interval_exp_o
);
    import lhi_pkg::*;

    initial begin
        if (POS_W < EXP_MAX + 1) begin
            $error("lhi_core: POS_W too narrow for the largest interval");
        end
    end

    // ****************************************************************
    // Reference mark synchroniser and edge
    // ****************************************************************
    logic mark_s1;
    logic mark_s2;
    logic mark_s3;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mark_s1 <= 1'b0;
            mark_s2 <= 1'b0;
            mark_s3 <= 1'b0;
        end else begin
            mark_s1 <= ref_mark_i;
            mark_s2 <= mark_s1;
            mark_s3 <= mark_s2;
        end
    end

    wire mark_rise = mark_s2 & ~mark_s3;

    // ****************************************************************
    // Homing sequence
    // ****************************************************************
    lhi_state_e       state;
    lhi_state_e       next_state;
    logic [SEL_W-1:0] sel_lat;
    logic [POS_W-1:0] reference;

    wire in_seek  = (state == LHI_SEEK);
    wire in_armed = (state == LHI_ARMED);

    always_comb begin
        next_state = state;
        if (homing_start_i) begin
            next_state = encoder_absolute_i ? LHI_ARMED : LHI_SEEK;
        end else if (in_seek && mark_rise) begin
            next_state = LHI_ARMED; // RULE_02
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state     <= LHI_IDLE;
            sel_lat   <= SEL_RESET; // RULE_01
            reference <= '0;
        end else begin
            state <= next_state;
            if (homing_start_i) begin
                sel_lat <= homing_interval_select_i;
                if (encoder_absolute_i) begin
                    reference <= POS_W'(ABS_ORIGIN); // RULE_05
                end
            end else if (in_seek && mark_rise) begin
                reference <= position_i; // RULE_02
            end
        end
    end

    // ****************************************************************
    // Power-of-two interval test
    // ****************************************************************
    wire [EXP_W-1:0] cur_exp = lhi_exp(sel_lat); // RULE_01
    wire [POS_W-1:0] one_w   = {{(POS_W-1){1'b0}}, 1'b1};
    wire [POS_W-1:0] mask    = (one_w << cur_exp) - one_w;
    wire [POS_W-1:0] offset  = position_i - reference;
    wire             on_grid = ((offset & mask) == '0); // RULE_08

    // Extra marks only matter when the scale is declared single-mark
    wire extra_set = in_armed & mark_rise & ~multi_reference_mark_enable_i;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            home_hit_o      <= 1'b0;
            extra_mark_o    <= 1'b0;
            seeking_o       <= 1'b0;
            armed_o         <= 1'b0;
            reference_pos_o <= '0;
            interval_exp_o  <= EXP_SEL3;
        end else begin
            home_hit_o      <= in_armed & on_grid; // RULE_08
            extra_mark_o    <= extra_set | (extra_mark_o & ~homing_start_i);
            seeking_o       <= (next_state == LHI_SEEK);
            armed_o         <= (next_state == LHI_ARMED);
            reference_pos_o <= reference;
            interval_exp_o  <= cur_exp; // RULE_01
        end
    end

    // ****************************************************************
    // Magnetic pole data store
    // ****************************************************************
    lhi_pole_mem #(
        .WIDTH (POLE_W),
        .DEPTH (POLE_DEPTH),
        .AW    (POLE_AW)
    ) u_pole_mem (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (pole_wr_en_i), // RULE_06
        .rd_en_i   (pole_rd_en_i), // RULE_06
        .addr_i    (pole_addr_i),
        .wdata_i   (pole_wdata_i),
        .rdata_o   (pole_rdata_o)
    );

    // Written data stays pending until the next power-up reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pole_rvalid_o  <= 1'b0;
            pole_written_o <= 1'b0;
        end else begin
            pole_rvalid_o  <= pole_rd_en_i;
            pole_written_o <= pole_written_o | pole_wr_en_i; // RULE_07
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic started;
    logic [POS_W-1:0] pos_d;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            started <= 1'b0;
            pos_d   <= '0;
        end else begin
            started <= started | homing_start_i;
            pos_d   <= position_i;
        end
    end

    property p_sel_default;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !started |=> (interval_exp_o == EXP_SEL3);
    endproperty
    a_sel_default: assert property (p_sel_default) else $error("default interval wrong"); // RULE_01

    property p_sel_decode;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        homing_start_i && homing_interval_select_i == 3'h7 ##1 !homing_start_i
        |=> (interval_exp_o == 5'h1e);
    endproperty
    a_sel_decode: assert property (p_sel_decode) else $error("code 7 not 2^30"); // RULE_01

    property p_abs_origin;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        homing_start_i && encoder_absolute_i |=> armed_o ##1 (reference_pos_o == '0);
    endproperty
    a_abs_origin: assert property (p_abs_origin) else $error("absolute origin not zero"); // RULE_05

    property p_inc_seek;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        homing_start_i && !encoder_absolute_i |=> seeking_o && !armed_o;
    endproperty
    a_inc_seek: assert property (p_inc_seek) else $error("incremental did not seek"); // RULE_02

    sequence s_mark_in_seek;
        in_seek && mark_rise && !homing_start_i;
    endsequence
    property p_mark_latch;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        s_mark_in_seek |=> armed_o ##1 (reference_pos_o == $past(pos_d));
    endproperty
    a_mark_latch: assert property (p_mark_latch) else $error("mark position not latched"); // RULE_02

    property p_home_hit;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        in_armed && ((((position_i - reference) >> cur_exp) << cur_exp) == (position_i - reference))
        |=> home_hit_o;
    endproperty
    a_home_hit: assert property (p_home_hit) else $error("missed home grid point"); // RULE_08

    property p_no_hit_idle;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !in_armed |=> !home_hit_o;
    endproperty
    a_no_hit_idle: assert property (p_no_hit_idle) else $error("hit while not armed"); // RULE_08

    sequence s_write_then_read;
        pole_wr_en_i ##1 (pole_rd_en_i && !pole_wr_en_i && pole_addr_i == $past(pole_addr_i));
    endsequence
    property p_pole_roundtrip;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        s_write_then_read |=> pole_rvalid_o && (pole_rdata_o == $past(pole_wdata_i, 2));
    endproperty
    a_pole_roundtrip: assert property (p_pole_roundtrip) else $error("pole data mismatch"); // RULE_06

endmodule // lhi_core

// ---- rtl/lhi_pkg.sv ----
package lhi_pkg;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int          POS_W       = 32;
    localparam int          EXP_W       = 5;
    localparam int          SEL_W       = 3;
    localparam int          POLE_W      = 16;
    localparam int          POLE_DEPTH  = 8;
    localparam int          POLE_AW     = 3;
    localparam logic [2:0]  SEL_RESET   = 3'h3;
    localparam logic [31:0] ABS_ORIGIN  = 32'h0;

    // ****************************************************************
    // Interval exponents per selector code
    // ****************************************************************
    localparam logic [4:0]  EXP_SEL0    = 5'h0d;
    localparam logic [4:0]  EXP_SEL1    = 5'h11;
    localparam logic [4:0]  EXP_SEL2    = 5'h12;
    localparam logic [4:0]  EXP_SEL3    = 5'h14;
    localparam logic [4:0]  EXP_SEL4    = 5'h16;
    localparam logic [4:0]  EXP_SEL5    = 5'h18;
    localparam logic [4:0]  EXP_SEL6    = 5'h1a;
    localparam logic [4:0]  EXP_SEL7    = 5'h1e;
    localparam int          EXP_MAX     = 30;

    typedef enum logic [1:0] {
        LHI_IDLE  = 2'b00,
        LHI_SEEK  = 2'b01,
        LHI_ARMED = 2'b10
    } lhi_state_e;

    function automatic logic [4:0] lhi_exp(input logic [2:0] sel);
        logic [4:0] e;
        e = EXP_SEL3;
        unique case (sel)
            3'h0: e = EXP_SEL0;
            3'h1: e = EXP_SEL1;
            3'h2: e = EXP_SEL2;
            3'h3: e = EXP_SEL3;
            3'h4: e = EXP_SEL4;
            3'h5: e = EXP_SEL5;
            3'h6: e = EXP_SEL6;
            3'h7: e = EXP_SEL7;
        endcase
        return e;
    endfunction

endpackage

// ---- rtl/lhi_pole_mem.sv ----
`timescale 1ns/10ps
module lhi_pole_mem #(
    parameter int WIDTH = lhi_pkg::POLE_W,
    parameter int DEPTH = lhi_pkg::POLE_DEPTH,
    parameter int AW    = lhi_pkg::POLE_AW
) (
    input  wire logic             ref_clk_i,
    input  wire logic             wr_en_i,
    input  wire logic             rd_en_i,
    input  wire logic [AW-1:0]    addr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    output logic      [WIDTH-1:0] rdata_o
);
    import lhi_pkg::*;

    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("lhi_pole_mem: DEPTH does not fit AW");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (rd_en_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule // lhi_pole_mem

// ---- verif/lhi_enc_model.sv ----
`timescale 1ns/10ps
module lhi_enc_model #(
    parameter logic [31:0] MARK_POS = 32'h0000_3039,
    parameter logic [31:0] MARK_W   = 32'h4
) (
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [31:0] target_i,
    output logic      [31:0] position_o,
    output logic             ref_mark_o
);
    wire logic [31:0] mark_off = target_i - MARK_POS;
    wire logic        on_mark  = mark_off < MARK_W;

    // Mark has a finite width starting at its position and extending MARK_W counts upward
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            position_o <= 32'h0;
            ref_mark_o <= 1'b0;
        end else begin
            position_o <= target_i;
            ref_mark_o <= on_mark;
        end
    end
endmodule // lhi_enc_model

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import lhi_pkg::*;
    typedef struct {logic [2:0] sel; logic [4:0] ex;} lhi_row_s;
    logic        ref_clk_i, arst_n_i, homing_start_i, abs_mode, multi_en, pole_wr, pole_rd;
    logic [2:0]  sel, pole_addr;
    logic [15:0] pole_wdata;
    logic [31:0] target;
    wire logic [31:0] position, reference_pos;
    wire logic [15:0] pole_rdata;
    wire logic [4:0]  interval_exp;
    wire logic        ref_mark, rvalid, pole_written, seeking, armed, home_hit, extra_mark;
    int errors, compares, cycles;
    lhi_row_s rows [8] = '{'{3'h0, 5'hd}, '{3'h1, 5'h11}, '{3'h2, 5'h12}, '{3'h3, 5'h14},
                           '{3'h4, 5'h16}, '{3'h5, 5'h18}, '{3'h6, 5'h1a}, '{3'h7, 5'h1e}};

    lhi_enc_model i_lhi_enc_model (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .target_i(target), .position_o(position), .ref_mark_o(ref_mark));
    lhi_core i_lhi_core (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .position_i(position),
        .ref_mark_i(ref_mark), .homing_start_i(homing_start_i), .encoder_absolute_i(abs_mode),
        .homing_interval_select_i(sel), .multi_reference_mark_enable_i(multi_en),
        .pole_wr_en_i(pole_wr), .pole_rd_en_i(pole_rd), .pole_addr_i(pole_addr),
        .pole_wdata_i(pole_wdata), .pole_rdata_o(pole_rdata), .pole_rvalid_o(rvalid),
        .pole_written_o(pole_written), .seeking_o(seeking), .armed_o(armed),
        .home_hit_o(home_hit), .extra_mark_o(extra_mark), .reference_pos_o(reference_pos),
        .interval_exp_o(interval_exp));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic start(input logic a, input logic [2:0] s);
        @(negedge ref_clk_i) {homing_start_i, abs_mode, sel} = {1'b1, a, s};
        @(negedge ref_clk_i) homing_start_i = 1'b0;
    endtask
    task automatic pole_rw(input logic wr, input logic [2:0] a, input logic [15:0] d);
        @(negedge ref_clk_i) {pole_wr, pole_rd, pole_addr, pole_wdata} = {wr, ~wr, a, d};
        @(negedge ref_clk_i) {pole_wr, pole_rd} = 2'b00;
    endtask
    task automatic end_of_test();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {arst_n_i, homing_start_i, abs_mode, multi_en, pole_wr, pole_rd} = 6'h0;
        {sel, pole_addr, pole_wdata, target} = '0;
        step(2);
        arst_n_i = 1'b1;
        step(1);
        chk_word(32'(interval_exp), 32'h14);
        chk_bit(armed, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            target = 32'h0;
            start(1'b1, rows[i].sel);
            step(2);
            chk_word(32'(interval_exp), 32'(rows[i].ex));
            chk_bit(armed, 1'b1);
            chk_word(reference_pos, 32'h0);
            target = 32'h3 << rows[i].ex;
            step(3);
            chk_bit(home_hit, 1'b1);
            target = target | (32'h1 << (rows[i].ex - 5'h1));
            step(3);
            chk_bit(home_hit, 1'b0);
        end
        $display("test absolute grid done");
        target = 32'h64;
        start(1'b0, 3'h0);
        chk_bit(seeking, 1'b1);
        step(3);
        target = 32'h3039;
        step(6);
        chk_bit(armed, 1'b1);
        chk_word(reference_pos, 32'h3039);
        target = 32'h2000;
        step(3);
        chk_bit(home_hit, 1'b0);
        target = 32'h5039;
        step(3);
        chk_bit(home_hit, 1'b1);
        target = 32'h3039;
        step(6);
        chk_bit(extra_mark, 1'b1);
        multi_en = 1'b1;
        target = 32'h64;
        start(1'b0, 3'h0);
        chk_bit(extra_mark, 1'b0);
        target = 32'h3039;
        step(6);
        target = 32'h64;
        step(3);
        target = 32'h3039;
        step(6);
        chk_bit(extra_mark, 1'b0);
        start(1'b1, 3'h3);
        step(2);
        chk_word(reference_pos, 32'h0);
        chk_bit(home_hit, 1'b0);
        $display("test incremental done");
        pole_rw(1'b1, 3'h5, 16'ha5c3);
        pole_rw(1'b0, 3'h5, 16'h0);
        chk_bit(rvalid, 1'b1);
        chk_word(32'(pole_rdata), 32'ha5c3);
        chk_bit(pole_written, 1'b1);
        @(negedge ref_clk_i) {pole_wr, pole_rd, pole_addr, pole_wdata} = {2'b10, 3'h2, 16'h3c5a};
        @(negedge ref_clk_i) {pole_wr, pole_rd} = 2'b01;
        @(negedge ref_clk_i) {pole_wr, pole_rd} = 2'b00;
        chk_bit(rvalid, 1'b1);
        chk_word(32'(pole_rdata), 32'h3c5a);
        step(1);
        arst_n_i = 1'b0;
        step(2);
        arst_n_i = 1'b1;
        chk_bit(pole_written, 1'b0);
        pole_rw(1'b0, 3'h5, 16'h0);
        chk_word(32'(pole_rdata), 32'ha5c3);
        $display("test pole data done");
        end_of_test();
    end
endmodule // tb_top
